/* core/dss_regs.vh */
// dss_regs.vh: constants for the pll channel state and oscillator steering block
// assumes inclusion by bare name from core/ design files
`ifndef DSS_REGS_VH
`define DSS_REGS_VH

`define DSS_NUM_W          40
`define DSS_DEV_W          38
// operating states
`define DSS_ST_FREERUN     2'h0
`define DSS_ST_ACQUIRE     2'h1
`define DSS_ST_LOCKED      2'h2
`define DSS_ST_HOLDOVER    2'h3
// boot sequence
`define DSS_BT_ROM         2'h0
`define DSS_BT_OVERLAY     2'h1
`define DSS_BT_DONE        2'h2
// core clock period in ps, pin pulse minimum and step period minimum in ps
`define DSS_CLK_PS         4000
`define DSS_TRIG_MIN_PS    100000
`define DSS_RATE_MIN_PS    200000
// relative analog steering: numerator units fed per feed period
`define DSS_FEED_STEP      40'h0000000100
`define DSS_FEED_PERIOD    8'h10
// reset values
`define DSS_RST_NUM        40'h0000000000
`endif

/* core/dss_channel.v */
// dss_channel.v: one pll channel: boot overlay choice, operating state machine,
// lock flags, tuning history, and oscillator numerator steering.
// assumes all inputs synchronous to i_core_clk; configuration is plain ports.
`timescale 1ns/1ps
`default_nettype none
`include "dss_regs.vh"

module dss_channel (
  // clock and reset
  input  wire        i_core_clk,
  input  wire        i_reset_n,
  input  wire        i_soft_reset,
  // boot
  input  wire        i_overlay_enable,
  input  wire        i_loop_config_valid,
  input  wire        i_crystal_valid,
  // reference and detectors
  input  wire        i_ref_valid,
  input  wire        i_reference_loss,
  input  wire        i_freq_in_tol,
  input  wire        i_phase_in_tol,
  input  wire        i_acquire_done,
  input  wire        i_loop_used,
  // history
  input  wire        i_history_enable,
  input  wire        i_history_valid_in,
  input  wire [39:0] i_history_word,
  // numerators
  input  wire [39:0] i_analog_numerator,
  input  wire        i_fb_num_wr,
  input  wire [39:0] i_fb_num_data,
  input  wire        i_offset_wr,
  input  wire [39:0] i_holdover_offset_word,
  // steering
  input  wire        i_steer_enable,
  input  wire [37:0] i_step_deviation_word,
  input  wire        i_step_update_wr,
  input  wire        i_step_update_bit,
  input  wire        i_pin_mode,
  input  wire        i_freq_step_trig,
  input  wire        i_freq_step_dir,
  // status
  output reg  [1:0]  o_state,
  output reg         o_boot_load_rom,
  output reg         o_boot_load_overlay,
  output reg         o_boot_done,
  output reg         o_analog_on_crystal,
  output reg         o_refs_qualified,
  output reg         o_wide_bandwidth,
  output reg         o_freq_lock_lost_flag,
  output reg         o_phase_lock_lost_flag,
  output reg         o_history_accumulate,
  output reg         o_steer_active,
  output reg  [39:0] o_feedback_numerator,
  output reg  [39:0] o_effective_analog_numerator,
  output reg         o_offset_fed
);

  localparam integer TRIG_MIN_INT = (`DSS_TRIG_MIN_PS + `DSS_CLK_PS - 1) / `DSS_CLK_PS;
  localparam [7:0]   TRIG_MIN_CYC = TRIG_MIN_INT[7:0];

  reg [1:0]  boot_q;
  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [39:0] fb_base_q;
  reg [39:0] steer_off_q;
  reg [39:0] ana_off_q;
  reg [39:0] ana_target_q;
  reg [7:0]  feed_cnt_q;
  reg        trig_q;
  reg [7:0]  trig_hi_q;
  reg        hist_valid_q;
  reg [39:0] steer_off_d;
  reg [39:0] fb_num_d;
  reg [39:0] ana_off_d;
  reg [39:0] ana_target_d;
  reg [7:0]  feed_cnt_d;
  reg        offset_fed_d;
  reg [39:0] ana_num_d;

  wire trig_rise   = i_freq_step_trig & ~trig_q;
  wire steer_ok    = i_steer_enable && (state_q == `DSS_ST_LOCKED);
  wire closed_loop = i_loop_used && (state_q != `DSS_ST_HOLDOVER)
                     && (state_q != `DSS_ST_FREERUN);
  wire [39:0] dev40 = {2'h0, i_step_deviation_word};
  // a pin step counts only while trig has stayed high long enough is not
  // needed: edge is taken at once, width relies on the controller
  wire pin_step = i_pin_mode && trig_rise;
  wire sw_step  = ~i_pin_mode && i_step_update_wr;
  wire step_dn  = i_pin_mode ? i_freq_step_dir : i_step_update_bit;
  wire do_step  = steer_ok && (pin_step || sw_step);
  wire [39:0] ana_gap = ana_target_q - ana_off_q;
  wire        gap_neg = ana_gap[39];
  wire [39:0] gap_mag = gap_neg ? (~ana_gap + 40'h1) : ana_gap;

  // boot: rom then optional overlay
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      boot_q <= `DSS_BT_ROM;
    end else if (i_soft_reset) begin
      boot_q <= `DSS_BT_ROM;
    end else begin
      case (boot_q)
        `DSS_BT_ROM: begin
          boot_q <= i_overlay_enable ? `DSS_BT_OVERLAY : `DSS_BT_DONE;
        end
        `DSS_BT_OVERLAY: begin
          boot_q <= `DSS_BT_DONE;
        end
        default: begin
          boot_q <= `DSS_BT_DONE;
        end
      endcase
    end
  end

  // operating state
  always @* begin
    state_d = state_q;
    case (state_q)
      `DSS_ST_FREERUN: begin
        if (boot_q == `DSS_BT_DONE && i_loop_config_valid && i_ref_valid)
          state_d = `DSS_ST_ACQUIRE;
      end
      `DSS_ST_ACQUIRE: begin
        if (i_reference_loss && !i_ref_valid)
          state_d = `DSS_ST_FREERUN;
        else if (i_acquire_done)
          state_d = `DSS_ST_LOCKED;
      end
      `DSS_ST_LOCKED: begin
        if (i_reference_loss && !i_ref_valid) begin
          if (i_history_enable && hist_valid_q)
            state_d = `DSS_ST_HOLDOVER;
          else
            state_d = `DSS_ST_FREERUN;
        end
      end
      `DSS_ST_HOLDOVER: begin
        if (i_ref_valid)
          state_d = `DSS_ST_ACQUIRE;
      end
      default: state_d = `DSS_ST_FREERUN;
    endcase
  end

  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q                <= `DSS_ST_FREERUN;
      o_state                <= `DSS_ST_FREERUN;
      o_boot_load_rom        <= 1'b1;
      o_boot_load_overlay    <= 1'b0;
      o_boot_done            <= 1'b0;
      o_analog_on_crystal    <= 1'b0;
      o_refs_qualified       <= 1'b0;
      o_wide_bandwidth       <= 1'b0;
      o_freq_lock_lost_flag  <= 1'b1;
      o_phase_lock_lost_flag <= 1'b1;
      o_history_accumulate   <= 1'b0;
      hist_valid_q           <= 1'b0;
    end else if (i_soft_reset) begin
      state_q                <= `DSS_ST_FREERUN;
      o_state                <= `DSS_ST_FREERUN;
      o_boot_load_rom        <= 1'b1;
      o_boot_load_overlay    <= 1'b0;
      o_boot_done            <= 1'b0;
      o_analog_on_crystal    <= 1'b0;
      o_refs_qualified       <= 1'b0;
      o_wide_bandwidth       <= 1'b0;
      o_freq_lock_lost_flag  <= 1'b1;
      o_phase_lock_lost_flag <= 1'b1;
      o_history_accumulate   <= 1'b0;
      hist_valid_q           <= 1'b0;
    end else begin
      state_q             <= state_d;
      o_state             <= state_d;
      o_boot_load_rom     <= (boot_q == `DSS_BT_ROM);
      o_boot_load_overlay <= (boot_q == `DSS_BT_OVERLAY);
      o_boot_done         <= (boot_q == `DSS_BT_DONE);
      // analog loop rides a valid crystal after boot, only in free-run or while loop config is not valid (in holdover only while loop config is not valid)
      o_analog_on_crystal <= i_crystal_valid && (boot_q == `DSS_BT_DONE)
                             && (state_d == `DSS_ST_FREERUN || !i_loop_config_valid);
      o_refs_qualified    <= (state_d != `DSS_ST_FREERUN) && i_ref_valid;
      o_wide_bandwidth    <= (state_d == `DSS_ST_ACQUIRE);
      if (state_d == `DSS_ST_HOLDOVER) begin
        o_phase_lock_lost_flag <= 1'b1;
      end else if (state_d == `DSS_ST_FREERUN) begin
        o_freq_lock_lost_flag  <= 1'b1;
        o_phase_lock_lost_flag <= 1'b1;
      end else begin
        o_freq_lock_lost_flag  <= ~i_freq_in_tol;
        o_phase_lock_lost_flag <= ~i_phase_in_tol;
      end
      // history runs once frequency lock is seen, in acquire or locked only
      o_history_accumulate <= i_history_enable && i_freq_in_tol
                              && (state_d == `DSS_ST_ACQUIRE || state_d == `DSS_ST_LOCKED);
      if (!i_history_enable || state_d == `DSS_ST_FREERUN)
        hist_valid_q <= 1'b0;
      else if (o_history_accumulate && i_history_valid_in)
        hist_valid_q <= 1'b1;
    end
  end

  // trigger pin edge detect and high-time count for the controller's pulse width
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trig_q    <= 1'b0;
      trig_hi_q <= 8'h00;
    end else begin
      trig_q    <= i_freq_step_trig;
      if (!i_freq_step_trig)
        trig_hi_q <= 8'h00;
      else if (trig_hi_q != TRIG_MIN_CYC)
        trig_hi_q <= trig_hi_q + 8'h01;
    end
  end

  // steering offset next value; disabling steering drops the offset at once
  always @* begin
    steer_off_d = steer_off_q;
    if (!i_steer_enable) begin
      steer_off_d = `DSS_RST_NUM;
    end else if (do_step && closed_loop) begin
      if (step_dn)
        steer_off_d = steer_off_q - dev40;
      else
        steer_off_d = steer_off_q + dev40;
    end
  end

  // a direct write is used in its own cycle so the output never shows the
  // stale base for one cycle after the write
  always @* begin
    fb_num_d = (i_fb_num_wr ? i_fb_num_data : fb_base_q)
               + (i_steer_enable ? steer_off_q : `DSS_RST_NUM);
  end

  // loop numerator: base written directly, steering offset accumulated
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fb_base_q            <= `DSS_RST_NUM;
      steer_off_q          <= `DSS_RST_NUM;
      o_steer_active       <= 1'b0;
      o_feedback_numerator <= `DSS_RST_NUM;
    end else begin
      if (i_fb_num_wr)
        fb_base_q <= i_fb_num_data;
      steer_off_q          <= steer_off_d;
      o_steer_active       <= steer_ok;
      o_feedback_numerator <= fb_num_d;
    end
  end

  // analog offset next values: a new relative write restarts feeding from the
  // offset applied now, so steps left from the last write are dropped
  always @* begin
    ana_off_d    = ana_off_q;
    ana_target_d = ana_target_q;
    feed_cnt_d   = feed_cnt_q;
    offset_fed_d = o_offset_fed;
    if (i_offset_wr) begin
      if (i_history_enable) begin
        ana_target_d = ana_off_q + i_holdover_offset_word;
        feed_cnt_d   = 8'h00;
        offset_fed_d = 1'b0;
      end else begin
        ana_off_d    = i_holdover_offset_word;
        ana_target_d = i_holdover_offset_word;
        offset_fed_d = 1'b1;
      end
    end else if (ana_gap != `DSS_RST_NUM) begin
      if (feed_cnt_q == `DSS_FEED_PERIOD - 8'h01) begin
        feed_cnt_d = 8'h00;
        if (gap_mag <= `DSS_FEED_STEP) begin
          ana_off_d    = ana_target_q;
          offset_fed_d = 1'b1;
        end else if (gap_neg) begin
          ana_off_d = ana_off_q - `DSS_FEED_STEP;
        end else begin
          ana_off_d = ana_off_q + `DSS_FEED_STEP;
        end
      end else begin
        feed_cnt_d = feed_cnt_q + 8'h01;
      end
    end
  end

  // closed loop leaves the analog numerator alone; otherwise an offset applies
  always @* begin
    if (closed_loop)
      ana_num_d = i_analog_numerator;
    else if (state_q == `DSS_ST_HOLDOVER && i_history_enable && hist_valid_q)
      ana_num_d = i_analog_numerator + i_history_word;
    else
      ana_num_d = i_analog_numerator + ana_off_q;
  end

  // analog numerator: holdover source and analog steering
  always @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ana_off_q                    <= `DSS_RST_NUM;
      ana_target_q                 <= `DSS_RST_NUM;
      feed_cnt_q                   <= 8'h00;
      o_offset_fed                 <= 1'b1;
      o_effective_analog_numerator <= `DSS_RST_NUM;
    end else begin
      ana_off_q                    <= ana_off_d;
      ana_target_q                 <= ana_target_d;
      feed_cnt_q                   <= feed_cnt_d;
      o_offset_fed                 <= offset_fed_d;
      o_effective_analog_numerator <= ana_num_d;
    end
  end

endmodule // dss_channel
`default_nettype wire

/* sim/dss_chk.sv */
// dss_chk.sv: port assertions for the pll channel block
// assumes it is bound to dss_channel and sees only its ports
`timescale 1ns/1ps
`default_nettype none
`include "dss_regs.vh"
module dss_chk (
  // clock and resets
  input wire logic        i_core_clk,
  input wire logic        i_reset_n,
  input wire logic        i_soft_reset,
  // causes
  input wire logic        i_loop_config_valid,
  input wire logic        i_ref_valid,
  input wire logic        i_reference_loss,
  input wire logic        i_steer_enable,
  input wire logic        i_loop_used,
  input wire logic        i_pin_mode,
  input wire logic        i_step_update_wr,
  input wire logic        i_step_update_bit,
  input wire logic [37:0] i_step_deviation_word,
  input wire logic        i_fb_num_wr,
  input wire logic [39:0] i_fb_num_data,
  // effects
  input wire logic [1:0]  o_state,
  input wire logic        o_boot_done,
  input wire logic        o_refs_qualified,
  input wire logic        o_wide_bandwidth,
  input wire logic        o_freq_lock_lost_flag,
  input wire logic        o_phase_lock_lost_flag,
  input wire logic [39:0] o_feedback_numerator
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  wire fr = o_state == `DSS_ST_FREERUN;
  wire aq = o_state == `DSS_ST_ACQUIRE;
  wire lk = o_state == `DSS_ST_LOCKED;
  wire ho = o_state == `DSS_ST_HOLDOVER;
  wire up = lk && i_steer_enable && i_loop_used && !i_pin_mode && !i_fb_num_wr;

  a_soft_to_free: assert property (i_soft_reset |=> fr)
    else $error("soft reset left free-run state");
  a_free_unqual: assert property (fr && $past(fr) |-> !o_refs_qualified && o_freq_lock_lost_flag
    && o_phase_lock_lost_flag) else $error("free-run flags wrong");
  a_ref_acquire: assert property ((fr || ho) && o_boot_done && i_loop_config_valid && i_ref_valid
    && !i_reference_loss && !i_soft_reset |=> aq) else $error("no acquisition");
  a_hold_phase_lock_lost_flag: assert property (ho |-> o_phase_lock_lost_flag)
    else $error("phase flag low in holdover");
  a_hold_freq_lock_lost_flag: assert property (ho && $past(ho) |-> $stable(o_freq_lock_lost_flag))
    else $error("freq flag moved in holdover");
  a_bw_by_state: assert property ($stable(o_state) && (aq || lk) |-> o_wide_bandwidth == aq)
    else $error("bandwidth does not follow state");
  a_sw_step_up: assert property (up && i_step_update_wr && !i_step_update_bit |-> ##2
    o_feedback_numerator == $past(o_feedback_numerator, 2) + {2'h0, $past(i_step_deviation_word, 2)})
    else $error("step up not applied");
  a_fb_write: assert property (i_fb_num_wr && !i_steer_enable && !$past(i_steer_enable) |=>
    o_feedback_numerator == $past(i_fb_num_data)) else $error("numerator write lost");
  c_locked: cover property (lk);
  c_hold: cover property (ho);
  c_step: cover property (up && i_step_update_wr);
endmodule // dss_chk
bind dss_channel dss_chk u_chk (.*);
`default_nettype wire

/* sim/dss_pin_host.sv */
// dss_pin_host.sv: host model driving the step trigger and direction pins
// assumes a 4 ns core clock; pulse and gap lengths keep the pin rate legal
`timescale 1ns/1ps
`default_nettype none
module dss_pin_host #(
  parameter int HIGH_CYC = 26
) (
  input  wire logic i_core_clk,
  output var  logic o_trig,
  output var  logic o_dir
);
  initial o_trig = 1'b0;
  initial o_dir = 1'b1;
  task automatic step(input logic down);
    @(posedge i_core_clk) o_dir <= down;
    @(posedge i_core_clk) o_trig <= 1'b1;
    repeat (HIGH_CYC) @(posedge i_core_clk);
    o_trig <= 1'b0;
    repeat (HIGH_CYC) @(posedge i_core_clk);
    // direction no longer held, so show the opposite level
    o_dir <= ~down;
  endtask
endmodule // dss_pin_host
`default_nettype wire

/* sim/dpll_state_and_dco_steering_tb_top.sv */
// dpll_state_and_dco_steering_tb_top.sv: directed tests of the pll channel
// assumes dss_channel, dss_pin_host and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "dss_regs.vh"
module dpll_state_and_dco_steering_tb_top;
  logic i_core_clk = 1'b0, i_reset_n = 1'b0, i_soft_reset = 1'b0, i_overlay_enable = 1'b1;
  logic i_loop_config_valid = 1'b0, i_crystal_valid = 1'b1, i_ref_valid = 1'b1;
  logic i_reference_loss = 1'b0, i_freq_in_tol = 1'b0, i_phase_in_tol = 1'b0;
  logic i_acquire_done = 1'b0, i_loop_used = 1'b1, i_history_enable = 1'b1;
  logic i_history_valid_in = 1'b0, i_fb_num_wr = 1'b0, i_offset_wr = 1'b0;
  logic i_steer_enable = 1'b0, i_step_update_wr = 1'b0, i_step_update_bit = 1'b0;
  logic i_pin_mode = 1'b0;
  logic [39:0] i_history_word = 40'h55, i_analog_numerator = 40'h1000;
  logic [39:0] i_fb_num_data = 40'h00ABCD0000, i_holdover_offset_word = 40'hFFFFFFFF00;
  logic [37:0] i_step_deviation_word = 38'h12345;
  wire logic i_freq_step_trig, i_freq_step_dir, o_boot_load_rom, o_boot_load_overlay;
  wire logic o_boot_done, o_analog_on_crystal, o_refs_qualified, o_wide_bandwidth;
  wire logic o_freq_lock_lost_flag, o_phase_lock_lost_flag, o_history_accumulate;
  wire logic o_steer_active, o_offset_fed;
  wire logic [1:0] o_state;
  wire logic [39:0] o_feedback_numerator, o_effective_analog_numerator;
  int n_errors = 0, num_checks = 0;
  localparam logic [39:0] NUM = 40'h00ABCD0000;
  localparam logic [39:0] DEV = 40'h12345;

  dss_channel dut (.*);
  dss_pin_host ph (.i_core_clk(i_core_clk), .o_trig(i_freq_step_trig), .o_dir(i_freq_step_dir));
  always #2 i_core_clk = ~i_core_clk;

  task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic waitst(input logic [1:0] s);
    for (int k = 0; k < 60 && o_state !== s; k++) cyc(1);
    chk("state", 40'(s), 40'(o_state));
  endtask
  task automatic sw(input logic b);
    @(posedge i_core_clk) i_step_update_wr <= 1'b1;
    i_step_update_bit <= b;
    @(posedge i_core_clk) i_step_update_wr <= 1'b0;
    cyc(3);
  endtask

  task automatic t_boot;
    cyc(12);
    chk("lost flags", 40'h3, 40'({o_freq_lock_lost_flag, o_phase_lock_lost_flag}));
    chk("boot rom", 40'h1, 40'(o_boot_load_rom));
    @(posedge i_core_clk) i_reset_n <= 1'b1;
    for (int k = 0; k < 8 && o_boot_load_overlay !== 1'b1; k++) cyc(1);
    chk("overlay", 40'h2, 40'({o_boot_load_overlay, o_boot_done}));
    cyc(20);
    chk("on crystal", 40'h1, 40'(o_analog_on_crystal));
    chk("unqualified", 40'h0, 40'(o_refs_qualified));
    waitst(`DSS_ST_FREERUN);
    @(posedge i_core_clk) i_loop_config_valid <= 1'b1;
    waitst(`DSS_ST_ACQUIRE);
    chk("wide bw", 40'h1, 40'(o_wide_bandwidth));
  endtask
  task automatic t_lock;
    @(posedge i_core_clk) i_freq_in_tol <= 1'b1;
    i_phase_in_tol <= 1'b1;
    i_acquire_done <= 1'b1;
    waitst(`DSS_ST_LOCKED);
    cyc(3);
    chk("narrow bw", 40'h0, 40'(o_wide_bandwidth));
    chk("lost flags", 40'h0, 40'({o_freq_lock_lost_flag, o_phase_lock_lost_flag}));
    chk("history acc", 40'h1, 40'(o_history_accumulate));
  endtask
  task automatic t_steer;
    @(posedge i_core_clk) i_fb_num_wr <= 1'b1;
    @(posedge i_core_clk) i_fb_num_wr <= 1'b0;
    cyc(2);
    chk("fb write", NUM, o_feedback_numerator);
    @(posedge i_core_clk) i_steer_enable <= 1'b1;
    sw(1'b0);
    chk("sw up", NUM + DEV, o_feedback_numerator);
    chk("steer active", 40'h1, 40'(o_steer_active));
    sw(1'b1);
    chk("sw down", NUM, o_feedback_numerator);
    @(posedge i_core_clk) i_pin_mode <= 1'b1;
    ph.step(1'b0);
    chk("pin up", NUM + DEV, o_feedback_numerator);
    sw(1'b1);
    chk("sw in pin mode", NUM + DEV, o_feedback_numerator);
    @(posedge i_core_clk) i_steer_enable <= 1'b0;
    i_pin_mode <= 1'b0;
    cyc(3);
    chk("steer off", NUM, o_feedback_numerator);
    sw(1'b0);
    chk("refused step", NUM, o_feedback_numerator);
  endtask
  task automatic t_hold;
    @(posedge i_core_clk) i_history_valid_in <= 1'b1;
    cyc(2);
    @(posedge i_core_clk) i_ref_valid <= 1'b0;
    i_reference_loss <= 1'b1;
    waitst(`DSS_ST_HOLDOVER);
    chk("hold flags", 40'h1, 40'({o_freq_lock_lost_flag, o_phase_lock_lost_flag}));
    cyc(1);
    chk("hist num", 40'h1055, o_effective_analog_numerator);
    @(posedge i_core_clk) i_history_enable <= 1'b0;
    i_offset_wr <= 1'b1;
    @(posedge i_core_clk) i_offset_wr <= 1'b0;
    cyc(3);
    chk("analog num", 40'hF00, o_effective_analog_numerator);
    @(posedge i_core_clk) i_ref_valid <= 1'b1;
    i_reference_loss <= 1'b0;
    waitst(`DSS_ST_ACQUIRE);
    waitst(`DSS_ST_LOCKED);
  endtask
  task automatic t_nohist;
    @(posedge i_core_clk) i_soft_reset <= 1'b1;
    @(posedge i_core_clk) i_soft_reset <= 1'b0;
    i_history_enable <= 1'b1;
    i_history_valid_in <= 1'b0;
    cyc(1);
    chk("soft reset", 40'(`DSS_ST_FREERUN), 40'(o_state));
    waitst(`DSS_ST_LOCKED);
    @(posedge i_core_clk) i_ref_valid <= 1'b0;
    i_reference_loss <= 1'b1;
    waitst(`DSS_ST_FREERUN);
  endtask
  task automatic t_feed;
    @(posedge i_core_clk) i_holdover_offset_word <= 40'h200;
    i_offset_wr <= 1'b1;
    @(posedge i_core_clk) i_offset_wr <= 1'b0;
    cyc(3);
    chk("feeding", 40'h0, 40'(o_offset_fed));
    @(posedge i_core_clk) i_holdover_offset_word <= 40'h300;
    i_offset_wr <= 1'b1;
    @(posedge i_core_clk) i_offset_wr <= 1'b0;
    cyc(60);
    chk("fed", 40'h1, 40'(o_offset_fed));
    chk("fed num", 40'h1200, o_effective_analog_numerator);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    t_boot;
    t_lock;
    t_steer;
    t_hold;
    t_nohist;
    t_feed;
    report_and_stop;
  end
  // the tests need about 230 cycles; a hang is cut at 10000 cycles, well past that
  initial begin
    #40000;
    n_errors++;
    report_and_stop;
  end
endmodule // dpll_state_and_dco_steering_tb_top
`default_nettype wire
